// ### rtl/ifd_core.sv
// instruction fetch, field decode, operand routing and character buffer
// assumes core memory answers on mem_done in this clock domain and
// character pins arrive asynchronously
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
`include "ifd_defines.svh"

module ifd_core #(
    parameter int CHARS = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // core memory
    output ifd_pkg::ifd_mem_req_t mem_req,
    input wire ifd_pkg::ifd_word_t mem_rdata,
    input wire logic mem_done,
    // character pins
    input wire logic [5:0] char_in,
    input wire logic char_in_stb,
    output logic [5:0] char_out,
    output logic char_out_stb,
    input wire logic char_out_ack,
    output logic word_req
);
    import ifd_pkg::*;

    ifd_state_t state_r, state_nxt;
    ifd_mem_req_t mem_r, mem_nxt;
    ifd_addr_t p_r, p_nxt;
    ifd_word_t c_r, c_nxt, a_r, a_nxt, b_r, b_nxt, x_r, x_nxt;
    ifd_word_t war_r, war_nxt;
    logic [5:0] o_r, o_nxt;
    logic [5:0] scr_r, scr_nxt;
    logic [4:0] bit_r, bit_nxt;
    logic carry_r, carry_nxt;
    logic halted_r, halted_nxt;
    logic [15:0] wtime_r, wtime_nxt;
    logic [2:0] in_cnt_r, in_cnt_nxt, out_cnt_r, out_cnt_nxt;
    logic in_full_r, in_full_nxt;
    logic stb_r, stb_nxt, wreq_r, wreq_nxt;
    logic wait_r;
    logic [31:0] rdata_r;

    // three-stage pin synchronisers; a level counts once stages 2 and 3 agree
    logic [7:0] pin_in;
    logic [7:0] lvl_r, lvl_d_r;
    assign pin_in = {char_out_ack, char_in_stb, char_in};
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            logic [2:0] q_r;
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    q_r <= 3'h0;
                    lvl_r[gi] <= 1'b0;
                    lvl_d_r[gi] <= 1'b0;
                end else begin
                    q_r <= {q_r[1:0], pin_in[gi]};
                    lvl_d_r[gi] <= lvl_r[gi];
                    if (q_r[1] == q_r[2]) begin
                        lvl_r[gi] <= q_r[2];
                    end
                end
            end
        end
    endgenerate

    wire in_evt = lvl_r[6] & ~lvl_d_r[6];
    wire ack_evt = lvl_r[7] & ~lvl_d_r[7];
    wire [5:0] in_char = lvl_r[5:0];

    // instruction field views of the transfer register
    wire [5:0] op_fld = c_r[`IFD_OP_HI:`IFD_OP_LO];
    wire [13:0] adr_fld = c_r[`IFD_ADR_HI:0];
    wire idx_bit = c_r[`IFD_IDX_BIT];
    wire ind_bit = c_r[`IFD_IND_BIT];
    wire pop_bit = c_r[`IFD_POP_BIT];
    // bit 0 (vector bit 23) is never looked at
    wire [13:0] pop_entry = {7'h00, pop_bit, op_fld};

    // operation classes
    wire is_store = (o_r == `IFD_OP_STA) | (o_r == `IFD_OP_STB) | (o_r == `IFD_OP_STX)
        | (o_r == `IFD_OP_WIM);
    wire is_sub = (o_r == `IFD_OP_SUB);
    wire is_arith = is_sub | (o_r == `IFD_OP_ADD);
    wire last_bit = (bit_r == `IFD_LAST_BIT);

    // serial adder: subtract adds the inverted operand with carry in set
    wire m_bit = is_sub ? ~c_r[0] : c_r[0];
    wire sum_bit = a_r[0] ^ m_bit ^ carry_r;
    wire sum_cry = (a_r[0] & m_bit) | (a_r[0] & carry_r) | (m_bit & carry_r);

    // source bit for stores, taken from the low end first
    wire src_bit = (o_r == `IFD_OP_STA) ? a_r[0] :
        (o_r == `IFD_OP_STB) ? b_r[0] :
        (o_r == `IFD_OP_STX) ? x_r[0] : war_r[0];

    // bus strobes, declared ahead of the controller that reads the write
    wire bus_req = (read | write) & wait_r;
    wire bus_wr = write & ~wait_r; // write lands at the answering edge

    // phase controller: one step completes before the next transfer
    always_comb begin
        state_nxt = state_r;
        mem_nxt = mem_r;
        p_nxt = p_r;
        c_nxt = c_r;
        o_nxt = o_r;
        a_nxt = a_r;
        b_nxt = b_r;
        x_nxt = x_r;
        bit_nxt = bit_r;
        carry_nxt = carry_r;
        halted_nxt = halted_r;
        wtime_nxt = wtime_r;
        war_nxt = war_r;
        scr_nxt = scr_r;
        in_cnt_nxt = in_cnt_r;
        in_full_nxt = in_full_r;
        out_cnt_nxt = out_cnt_r;
        stb_nxt = stb_r;
        wreq_nxt = wreq_r;

        // character input: pin to single char reg, then into word reg
        // an offered char must stand, so input waits for the last ack too
        if (in_evt && !in_full_r && out_cnt_r == 3'h0 && !stb_r) begin
            scr_nxt = in_char;
        end
        if (lvl_d_r[6] && !lvl_r[6] && !in_full_r && out_cnt_r == 3'h0 && !stb_r) begin
            war_nxt = {war_r[17:0], scr_r};
            in_cnt_nxt = in_cnt_r + 3'h1;
            if (in_cnt_r == 3'(CHARS - 1)) begin
                in_full_nxt = 1'b1;
                in_cnt_nxt = 3'h0;
            end
        end

        // character output, one per acknowledge
        if (ack_evt) begin
            stb_nxt = 1'b0;
        end
        if (out_cnt_r != 3'h0 && !stb_r) begin
            scr_nxt = war_r[23:18];
            war_nxt = {war_r[17:0], 6'h00};
            stb_nxt = 1'b1;
            out_cnt_nxt = out_cnt_r - 3'h1;
            if (out_cnt_r == 3'h1) begin
                wreq_nxt = 1'b1;
            end
        end

        case (state_r)
            ST_IDLE: begin
            end
            ST_FETCH: begin
                p_nxt = p_r + 14'h0001;
                mem_nxt.addr = p_r + 14'h0001;
                mem_nxt.rd = 1'b1;
                wtime_nxt = wtime_r + 16'h0001;
                state_nxt = ST_FWAIT;
            end
            ST_FWAIT: begin
                if (mem_done) begin
                    mem_nxt.rd = 1'b0;
                    mem_nxt.data = mem_rdata;
                    state_nxt = ST_XFER;
                end
            end
            ST_XFER: begin
                c_nxt = mem_r.data;
                state_nxt = ST_INDEX;
            end
            ST_INDEX: begin
                o_nxt = op_fld;
                if (pop_bit) begin
                    p_nxt = pop_entry - 14'h0001;
                    state_nxt = ST_FETCH;
                end else if (idx_bit) begin
                    c_nxt[`IFD_ADR_HI:0] = adr_fld + x_r[`IFD_ADR_HI:0];
                    c_nxt[`IFD_IDX_BIT] = 1'b0;
                end else if (ind_bit) begin
                    mem_nxt.addr = adr_fld;
                    mem_nxt.rd = 1'b1;
                    wtime_nxt = wtime_r + 16'h0001;
                    state_nxt = ST_IWAIT;
                end else begin
                    state_nxt = ST_DISP;
                end
            end
            ST_IWAIT: begin
                if (mem_done) begin
                    // pointed word supplies address and further modifiers
                    mem_nxt.rd = 1'b0;
                    c_nxt[`IFD_ADR_HI:0] = mem_rdata[`IFD_ADR_HI:0];
                    c_nxt[`IFD_IND_BIT] = mem_rdata[`IFD_IND_BIT];
                    c_nxt[`IFD_IDX_BIT] = mem_rdata[`IFD_IDX_BIT];
                    state_nxt = ST_INDEX;
                end
            end
            ST_DISP: begin
                bit_nxt = 5'h00;
                carry_nxt = is_sub;
                mem_nxt.addr = adr_fld;
                case (o_r)
                    `IFD_OP_HLT: begin
                        halted_nxt = 1'b1;
                        state_nxt = ST_HALT;
                    end
                    `IFD_OP_BRU: begin
                        p_nxt = adr_fld - 14'h0001;
                        state_nxt = ST_FETCH;
                    end
                    `IFD_OP_EAX: begin
                        x_nxt = {10'h000, adr_fld};
                        state_nxt = ST_FETCH;
                    end
                    `IFD_OP_STA, `IFD_OP_STB, `IFD_OP_STX: begin
                        state_nxt = ST_EXEC;
                    end
                    `IFD_OP_WIM: begin
                        // wait for a full input word
                        if (in_full_r) begin
                            state_nxt = ST_EXEC;
                        end
                    end
                    `IFD_OP_MIW: begin
                        // wait until the previous output word is gone
                        if (out_cnt_r == 3'h0 && !stb_r) begin
                            mem_nxt.rd = 1'b1;
                            wtime_nxt = wtime_r + 16'h0001;
                            state_nxt = ST_OWAIT;
                        end
                    end
                    `IFD_OP_ADD, `IFD_OP_SUB, `IFD_OP_LDA, `IFD_OP_LDB, `IFD_OP_LDX: begin
                        mem_nxt.rd = 1'b1;
                        wtime_nxt = wtime_r + 16'h0001;
                        state_nxt = ST_OWAIT;
                    end
                    // remaining codes of 00..77 run as no operation
                    default: begin
                        state_nxt = ST_FETCH;
                    end
                endcase
            end
            ST_OWAIT: begin
                if (mem_done) begin
                    mem_nxt.rd = 1'b0;
                    mem_nxt.data = mem_rdata;
                    state_nxt = ST_OLOAD;
                end
            end
            ST_OLOAD: begin
                c_nxt = mem_r.data;
                if (o_r == `IFD_OP_MIW) begin
                    in_cnt_nxt = 3'h0;
                end
                state_nxt = ST_EXEC;
            end
            ST_EXEC: begin
                // one bit per clock, low end first
                bit_nxt = bit_r + 5'h01;
                if (is_store) begin
                    c_nxt = {src_bit, c_r[23:1]};
                    case (o_r)
                        `IFD_OP_STA: a_nxt = {a_r[0], a_r[23:1]};
                        `IFD_OP_STB: b_nxt = {b_r[0], b_r[23:1]};
                        `IFD_OP_STX: x_nxt = {x_r[0], x_r[23:1]};
                        default: war_nxt = {war_r[0], war_r[23:1]};
                    endcase
                end else begin
                    c_nxt = {c_r[0], c_r[23:1]};
                    if (is_arith) begin
                        a_nxt = {sum_bit, a_r[23:1]};
                        carry_nxt = sum_cry;
                    end else if (o_r == `IFD_OP_LDA) begin
                        a_nxt = {c_r[0], a_r[23:1]};
                    end else if (o_r == `IFD_OP_LDB) begin
                        b_nxt = {c_r[0], b_r[23:1]};
                    end else if (o_r == `IFD_OP_LDX) begin
                        x_nxt = {c_r[0], x_r[23:1]};
                    end else begin
                        war_nxt = {c_r[0], war_r[23:1]};
                    end
                end
                if (last_bit) begin
                    wtime_nxt = wtime_r + 16'h0001;
                    if (is_store) begin
                        mem_nxt.data = {src_bit, c_r[23:1]};
                        mem_nxt.wr = 1'b1;
                        wtime_nxt = wtime_r + 16'h0002;
                        state_nxt = ST_SWAIT;
                    end else begin
                        if (o_r == `IFD_OP_MIW) begin
                            out_cnt_nxt = 3'(CHARS);
                            wreq_nxt = 1'b0;
                        end
                        state_nxt = ST_FETCH;
                    end
                end
            end
            ST_SWAIT: begin
                if (mem_done) begin
                    mem_nxt.wr = 1'b0;
                    if (o_r == `IFD_OP_WIM) begin
                        in_full_nxt = 1'b0;
                    end
                    state_nxt = ST_FETCH;
                end
            end
            ST_HALT: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase

        // software control and register loads while stopped
        if (bus_wr && state_r == ST_IDLE) begin
            if (address == `IFD_REG_PC) p_nxt = writedata[13:0];
            if (address == `IFD_REG_A) a_nxt = writedata[23:0];
            if (address == `IFD_REG_B) b_nxt = writedata[23:0];
            if (address == `IFD_REG_X) x_nxt = writedata[23:0];
        end
        if (bus_wr && address == `IFD_REG_CTRL) begin
            if (writedata[`IFD_CTRL_CLR]) begin
                wtime_nxt = 16'h0000;
                halted_nxt = 1'b0;
            end
            if (writedata[`IFD_CTRL_RUN] && state_r == ST_IDLE) begin
                halted_nxt = 1'b0;
                state_nxt = ST_FETCH;
            end
        end
    end

    // avalon slave: one wait cycle, then answer for one cycle
    wire [31:0] stat_w = {16'h0000, wreq_r, in_full_r, halted_r, 1'b0, 6'h00, o_r};
    wire [31:0] rd_mux =
        (address == `IFD_REG_CTRL) ? {31'h0, state_r != ST_IDLE} :
        (address == `IFD_REG_PC) ? {18'h0, p_r} :
        (address == `IFD_REG_STAT) ? stat_w :
        (address == `IFD_REG_A) ? {8'h00, a_r} :
        (address == `IFD_REG_B) ? {8'h00, b_r} :
        (address == `IFD_REG_X) ? {8'h00, x_r} :
        (address == `IFD_REG_C) ? {8'h00, c_r} :
        (address == `IFD_REG_WORD) ? {8'h00, war_r} :
        (address == `IFD_REG_TIME) ? {16'h0000, wtime_r} : 32'h0;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0;
        end else begin
            wait_r <= ~bus_req;
            if (bus_req) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // datapath and phase registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            mem_r <= '0;
            p_r <= 14'h0000;
            c_r <= 24'h0;
            a_r <= 24'h0;
            b_r <= 24'h0;
            x_r <= 24'h0;
            o_r <= 6'h00;
            bit_r <= 5'h00;
            carry_r <= 1'b0;
            halted_r <= 1'b0;
            wtime_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            mem_r <= mem_nxt;
            p_r <= p_nxt;
            c_r <= c_nxt;
            a_r <= a_nxt;
            b_r <= b_nxt;
            x_r <= x_nxt;
            o_r <= o_nxt;
            bit_r <= bit_nxt;
            carry_r <= carry_nxt;
            halted_r <= halted_nxt;
            wtime_r <= wtime_nxt;
        end
    end

    // character buffer registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            war_r <= 24'h0;
            scr_r <= 6'h00;
            in_cnt_r <= 3'h0;
            in_full_r <= 1'b0;
            out_cnt_r <= 3'h0;
            stb_r <= 1'b0;
            wreq_r <= 1'b0;
        end else begin
            war_r <= war_nxt;
            scr_r <= scr_nxt;
            in_cnt_r <= in_cnt_nxt;
            in_full_r <= in_full_nxt;
            out_cnt_r <= out_cnt_nxt;
            stb_r <= stb_nxt;
            wreq_r <= wreq_nxt;
        end
    end

    // outputs straight from flops
    assign readdata = rdata_r;
    assign waitrequest = wait_r;
    assign mem_req = mem_r;
    assign char_out = scr_r;
    assign char_out_stb = stb_r;
    assign word_req = wreq_r;

endmodule // ifd_core

// ### inc/ifd_defines.svh
// constants for the instruction fetch, decode and operand datapath
// assumes a single 100 MHz clock and an Avalon-MM host for the registers
`ifndef IFD_DEFINES_SVH
`define IFD_DEFINES_SVH

// instruction fields, vector bit = 23 - documented position
`define IFD_OP_HI 20
`define IFD_OP_LO 15
`define IFD_IND_BIT 14
`define IFD_IDX_BIT 22
`define IFD_POP_BIT 21
`define IFD_ADR_HI 13

// operation codes
`define IFD_OP_HLT 6'h00
`define IFD_OP_BRU 6'h01
`define IFD_OP_MIW 6'h0A
`define IFD_OP_WIM 6'h1A
`define IFD_OP_STA 6'h1D
`define IFD_OP_STB 6'h1E
`define IFD_OP_STX 6'h1F
`define IFD_OP_SUB 6'h2C
`define IFD_OP_ADD 6'h2D
`define IFD_OP_LDX 6'h39
`define IFD_OP_LDB 6'h3D
`define IFD_OP_LDA 6'h3E
`define IFD_OP_EAX 6'h3F

// register word indices
`define IFD_REG_CTRL 4'h0
`define IFD_REG_PC 4'h1
`define IFD_REG_STAT 4'h2
`define IFD_REG_A 4'h3
`define IFD_REG_B 4'h4
`define IFD_REG_X 4'h5
`define IFD_REG_C 4'h6
`define IFD_REG_WORD 4'h7
`define IFD_REG_TIME 4'h8

// control bits
`define IFD_CTRL_RUN 0
`define IFD_CTRL_CLR 1

// serial word length minus one
`define IFD_LAST_BIT 5'h17

`endif

// ### inc/ifd_pkg.sv
// types for the instruction fetch, decode and operand datapath
// assumes ifd_defines.svh supplies the numeric constants other than the state codes set here
package ifd_pkg;

    typedef logic [23:0] ifd_word_t;
    typedef logic [13:0] ifd_addr_t;

    // request to core memory: address register and buffer register travel together
    typedef struct packed {
        logic rd;
        logic wr;
        ifd_addr_t addr;
        ifd_word_t data;
    } ifd_mem_req_t;

    typedef enum logic [11:0] {
        ST_IDLE  = 12'h001,
        ST_FETCH = 12'h002,
        ST_FWAIT = 12'h004,
        ST_XFER  = 12'h008,
        ST_INDEX = 12'h010,
        ST_IWAIT = 12'h020,
        ST_DISP  = 12'h040,
        ST_OWAIT = 12'h080,
        ST_OLOAD = 12'h100,
        ST_EXEC  = 12'h200,
        ST_SWAIT = 12'h400,
        ST_HALT  = 12'h800
    } ifd_state_t;

endpackage

// ### tb/ifd_core_sva.sv
// port assertions for the fetch/decode core
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/10ps
module ifd_core_sva (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // register bus
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // memory and characters
    input wire ifd_pkg::ifd_mem_req_t mem_req,
    input wire logic mem_done,
    input wire logic [5:0] char_out,
    input wire logic char_out_stb,
    input wire logic char_out_ack
);
    import ifd_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // any memory access in flight
    wire logic busy = mem_req.rd || mem_req.wr;

    a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered next cycle");
    a_bus_single: assert property (!waitrequest |=> waitrequest)
        else $error("answer held more than one cycle");
    a_rdata_hold: assert property (waitrequest && $past(waitrequest) |-> $stable(readdata))
        else $error("read data moved between answers");
    a_unmapped_zero: assert property (read && !waitrequest && address > 4'h8 |-> readdata == 0)
        else $error("unmapped read not zero");
    a_mem_hold: assert property (busy && !mem_done |=> $stable(mem_req))
        else $error("memory request moved before done");
    a_mem_release: assert property (mem_done && busy |=> !busy)
        else $error("memory request not released after done");
    a_char_hold: assert property (char_out_stb && $past(char_out_stb) |-> $stable(char_out))
        else $error("char changed while offered");
    a_ack_drop: assert property (char_out_stb && $rose(char_out_ack) |-> ##[1:8] !char_out_stb)
        else $error("char offer not withdrawn after ack");
    c_read: cover property (read && !waitrequest);
    c_store: cover property (mem_req.wr && mem_done);
    c_char: cover property (char_out_stb && $rose(char_out_ack));
endmodule // ifd_core_sva

bind ifd_core ifd_core_sva i_sva (.clock(clock), .resetn(resetn), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .mem_req(mem_req), .mem_done(mem_done), .char_out(char_out),
    .char_out_stb(char_out_stb), .char_out_ack(char_out_ack));

// ### tb/ifd_mem_model.sv
// core memory and character sink facing the fetch/decode core
// assumes the bench preloads mem and seeds $urandom
`timescale 1ns/10ps
module ifd_mem_model (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // memory side
    input wire ifd_pkg::ifd_mem_req_t mem_req,
    output ifd_pkg::ifd_word_t mem_rdata,
    output logic mem_done,
    // character sink
    input wire logic char_out_stb,
    output logic char_out_ack
);
    import ifd_pkg::*;
    ifd_word_t mem [0:16383];
    logic [1:0] cnt_r = 2'h0;
    logic [1:0] lat_r = 2'h0;
    logic [1:0] acnt_r = 2'h0;
    initial begin
        mem_rdata = 24'h0;
        mem_done = 1'b0;
        char_out_ack = 1'b0;
    end
    // random latency; data toggles outside the answer cycle so stale words never match
    always @(posedge clock) begin
        mem_done <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (!resetn) begin
            cnt_r <= 2'h0;
        end else if ((mem_req.rd || mem_req.wr) && !mem_done) begin
            if (cnt_r == lat_r) begin
                mem_done <= 1'b1;
                cnt_r <= 2'h0;
                lat_r <= 2'($urandom_range(3));
                if (mem_req.wr)
                    mem[mem_req.addr] <= mem_req.data;
                else
                    mem_rdata <= mem[mem_req.addr];
            end else
                cnt_r <= cnt_r + 2'h1;
        end
    end
    // ack each offered char late, drop it once the offer goes away
    always @(posedge clock) begin
        if (!resetn || !char_out_stb) begin
            acnt_r <= 2'h0;
            char_out_ack <= 1'b0;
        end else if (acnt_r == 2'h3)
            char_out_ack <= 1'b1;
        else
            acnt_r <= acnt_r + 2'h1;
    end
endmodule // ifd_mem_model

// ### tb/instr_fetch_decode_datapath_tb.sv
// self-checking bench: runs a small program through the core
// assumes ifd_core, ifd_mem_model and the checker are compiled first
`timescale 1ns/10ps
`include "ifd_defines.svh"
module instr_fetch_decode_datapath_tb;
    import ifd_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, rdat;
    logic waitrequest, mem_done, char_in_stb = 1'b0;
    ifd_mem_req_t mem_req;
    ifd_word_t mem_rdata, wd;
    ifd_word_t v [7];
    logic [5:0] char_in = 6'h0;
    logic [5:0] char_out;
    logic char_out_stb, char_out_ack, word_req, stb_q;
    int num_errors = 0;
    int tests_run = 0;
    logic [37:0] exp_rd[$], exp_wr[$], exp_ch[$];

    always #5 clock = ~clock;

    ifd_core #(.CHARS(4)) i_dut (.clock(clock), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .mem_done(mem_done), .char_in(char_in), .char_in_stb(char_in_stb),
        .char_out(char_out), .char_out_stb(char_out_stb), .char_out_ack(char_out_ack),
        .word_req(word_req));
    ifd_mem_model i_mem (.clock(clock), .resetn(resetn), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .mem_done(mem_done), .char_out_stb(char_out_stb),
        .char_out_ack(char_out_ack));

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [37:0] seen, input logic [37:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one bus cycle: hold until waitrequest is seen low, then release
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        @(posedge clock);
        while (waitrequest !== 1'b0) begin
            if (++n > 50) begin
                num_errors++;
                test_done;
            end
            @(posedge clock);
        end
        rdat = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_rd.push_back(38'(e));
        bus(1'b0, a, 32'h0);
    endtask
    function automatic ifd_word_t ins(logic [2:0] f, logic [5:0] op, logic i, logic [13:0] a);
        return {f, op, i, a};
    endfunction

    // results leave in order; compare each against the oldest note
    always @(posedge clock) begin
        stb_q <= char_out_stb;
        if (read && !waitrequest && exp_rd.size() > 0)
            check(38'(readdata), exp_rd.pop_front());
        if (mem_req.wr && mem_done)
            check({mem_req.addr, mem_req.data}, exp_wr.pop_front());
        if (char_out_stb && !stb_q)
            check(38'(char_out), exp_ch.pop_front());
    end

    initial begin
        repeat (30000) @(posedge clock);
        num_errors++;
        test_done;
    end

    initial begin
        void'($urandom(32'hBE7C23B6));
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        foreach (v[i]) v[i] = 24'($urandom());
        i_mem.mem[1] = ins(3'h4, `IFD_OP_LDA, 1'b0, 14'h64);
        i_mem.mem[2] = ins(3'h0, `IFD_OP_ADD, 1'b0, 14'h65);
        i_mem.mem[3] = ins(3'h0, `IFD_OP_SUB, 1'b0, 14'h66);
        i_mem.mem[4] = ins(3'h0, `IFD_OP_LDX, 1'b0, 14'h67);
        i_mem.mem[5] = ins(3'h2, `IFD_OP_LDB, 1'b0, 14'h68);
        i_mem.mem[6] = ins(3'h0, `IFD_OP_STA, 1'b0, 14'h6E);
        i_mem.mem[7] = ins(3'h0, `IFD_OP_LDA, 1'b1, 14'h69);
        i_mem.mem[8] = ins(3'h2, `IFD_OP_STX, 1'b0, 14'h6E);
        i_mem.mem[9] = ins(3'h0, `IFD_OP_WIM, 1'b0, 14'h78);
        i_mem.mem[10] = ins(3'h0, `IFD_OP_MIW, 1'b0, 14'h79);
        i_mem.mem[11] = ins(3'h0, `IFD_OP_BRU, 1'b0, 14'h30);
        i_mem.mem[48] = ins(3'h1, 6'h05, 1'b0, 14'h0);
        i_mem.mem[69] = ins(3'h0, `IFD_OP_EAX, 1'b0, 14'hC8);
        i_mem.mem[70] = ins(3'h0, `IFD_OP_HLT, 1'b0, 14'h0);
        for (int i = 0; i < 3; i++) i_mem.mem[100 + i] = v[i];
        i_mem.mem[103] = 24'h5;
        i_mem.mem[109] = v[3];
        i_mem.mem[105] = 24'h6A;
        i_mem.mem[106] = v[4];
        i_mem.mem[121] = v[5];
        wd = v[0] + v[1] - v[2];
        exp_wr.push_back({14'h6E, wd});
        exp_wr.push_back({14'h73, 24'h5});
        exp_wr.push_back({14'h78, v[6]});
        for (int i = 0; i < 4; i++) exp_ch.push_back(38'(v[5][23 - 6 * i -: 6]));
        // characters arrive first, so the input word is full before the store
        for (int i = 0; i < 4; i++) begin
            char_in <= v[6][23 - 6 * i -: 6];
            repeat (2) @(posedge clock);
            char_in_stb <= 1'b1;
            repeat (6) @(posedge clock);
            char_in_stb <= 1'b0;
            repeat (6) @(posedge clock);
        end
        bus(1'b1, `IFD_REG_CTRL, 32'h2);
        bus(1'b1, `IFD_REG_PC, 32'h0);
        rd(`IFD_REG_PC, 32'h0);
        bus(1'b1, `IFD_REG_CTRL, 32'h1);
        rdat = 32'h0;
        for (int n = 0; n < 2000 && rdat[13] !== 1'b1; n++) bus(1'b0, `IFD_REG_STAT, 32'h0);
        repeat (200) @(posedge clock);
        check(38'(word_req), 38'h1);
        $display("test program done");
        rd(`IFD_REG_A, 32'(v[4]));
        rd(`IFD_REG_B, 32'(v[3]));
        rd(`IFD_REG_X, 32'hC8);
        rd(`IFD_REG_STAT, 32'hA000);
        rd(`IFD_REG_CTRL, 32'h0);
        rd(`IFD_REG_TIME, 32'h23);
        rd(4'h9, 32'h0);
        bus(1'b1, 4'hF, 32'h5A);
        rd(4'hF, 32'h0);
        repeat (4) @(posedge clock);
        $display("test registers done");
        test_done;
    end
endmodule // instr_fetch_decode_datapath_tb
